// *** dcf_pkg.sv ***
// Shared constants and types of the field delay memory and its controller
package dcf_pkg;

    // ****************************************
    // Data path
    // ****************************************
    localparam int NIB_W = 4;
    localparam int FIELD_DEPTH = 262263;
    localparam int HOLD_DEPTH = 120;

    // ****************************************
    // Pointer clear spacing, in shift cycles
    // ****************************************
    localparam int MIN_ACTIVE = 130;
    localparam int MIN_CLR_LOW = 2;
    localparam int OLD_MAX = 119;
    localparam int NEW_MIN = 600;

    // ****************************************
    // Timing
    // ****************************************
    localparam int CLK_MHZ = 40;
    localparam int POWER_UP_US = 100;
    localparam int POWER_UP_CYC = POWER_UP_US * CLK_MHZ;
    localparam int SHIFT_HALF = 2;

    // ****************************************
    // Counter widths of the controller
    // ****************************************
    localparam int TIMER_W = 12;
    localparam int ACT_W = 8;
    localparam int LOW_W = 2;
    localparam int SPACE_W = 10;

    // ****************************************
    // Controller states and init steps
    // ****************************************
    typedef enum logic [2:0] {
        ST_WAIT = 3'h1,
        ST_INIT = 3'h2,
        ST_RUN = 3'h4
    } dcf_ctl_state_t;

    localparam logic [1:0] INIT_CLR1 = 2'h0;
    localparam logic [1:0] INIT_DUMMY = 2'h1;
    localparam logic [1:0] INIT_DONE = 2'h2;

endpackage

// *** dcf_link_if.sv ***
// Serial port pins between the field memory and its video controller
`timescale 1ns/10ps
`default_nettype none
interface dcf_link_if;
    // Write port
    logic write_shift_clock;
    logic input_advance_gate;
    logic write_pointer_clear;
    logic [dcf_pkg::NIB_W-1:0] nibble_in;
    // Read port
    logic output_shift_clock;
    logic output_advance_gate;
    logic output_pointer_clear;
    logic [dcf_pkg::NIB_W-1:0] nibble_out;
    logic nibble_out_oe;

    modport dev (
        input write_shift_clock,
        input input_advance_gate,
        input write_pointer_clear,
        input nibble_in,
        input output_shift_clock,
        input output_advance_gate,
        input output_pointer_clear,
        output nibble_out,
        output nibble_out_oe
    );

    modport ctl (
        output write_shift_clock,
        output input_advance_gate,
        output write_pointer_clear,
        output nibble_in,
        output output_shift_clock,
        output output_advance_gate,
        output output_pointer_clear,
        input nibble_out,
        input nibble_out_oe
    );
endinterface
`default_nettype wire

// *** dcf_field_mem.sv ***
// Field delay memory: serial write and read ports over one storage array
//
// Overview of operation
// - Controller gives at least 130 active writes per field
// - Write clear pushes held nibbles into storage
// - Write clear edge zeroes address, gate ignored
// - Write clear low two cycles between clears
// - Gated write edge stores nibble, advances pointer
// - Gate low: no store, pointer holds
// - Gate high and low periods unlimited
// - Stopped shift clocks keep pointers and data
// - Controller gives at least 130 active reads per field
// - Read clear edge zeroes address, gate ignored
// - Read clear low two cycles between clears
// - Gated read edge outputs nibble, advances pointer
// - Read gate low: read pointer holds
// - Output same polarity, three-state driver
// - Controller waits 100 us after power-up
// - Init: 130 dummy cycles then clear, both ports
// - Unsettled start: clear, 130 cycles, clear
// - 600 write cycles between write and read
// - Read clear within 119 writes reads old
// - New field needs 600 cycles clear spacing
// - Spacing 120 to 599 gives undefined data
`timescale 1ns/10ps
`default_nettype none
module dcf_field_mem #(
    parameter int DEPTH = dcf_pkg::FIELD_DEPTH,
    parameter int HOLD = dcf_pkg::HOLD_DEPTH
) (
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_srst,
    // Link to the controller
    dcf_link_if.dev link,
    // Status
    output logic [$clog2(DEPTH)-1:0] o_write_addr,
    output logic [$clog2(DEPTH)-1:0] o_read_addr,
    output logic [$clog2(HOLD+1)-1:0] o_hold_level
);

    // ****************************************
    // Widths and state
    // ****************************************
    localparam int AW = $clog2(DEPTH);
    localparam int HW = $clog2(HOLD + 1);
    localparam int IW = $clog2(HOLD);
    localparam int NW = dcf_pkg::NIB_W;

    typedef struct packed {
        logic wclk;
        logic rclk;
        logic [AW-1:0] wr_ptr;
        logic [AW-1:0] rd_ptr;
        logic [IW-1:0] head;
        logic [HW-1:0] count;
        logic [HW-1:0] flush_left;
        logic [NW-1:0] nibble;
        logic oe;
    } dcf_mem_state_t;

    dcf_mem_state_t st_q;
    dcf_mem_state_t st_d;

    // ****************************************
    // Storage
    // ****************************************
    logic [NW-1:0] field_mem [DEPTH];
    logic [NW-1:0] hold_data [HOLD];
    logic [AW-1:0] hold_addr [HOLD];

    // ****************************************
    // Per-cycle strobes
    // ****************************************
    logic w_edge;
    logic r_edge;
    logic w_clr;
    logic push;
    logic commit;
    logic hold_full;
    logic [IW-1:0] push_idx;
    logic [AW-1:0] commit_addr;
    logic [NW-1:0] commit_data;

    // ****************************************
    // Helpers
    // ****************************************
    // Wraps at the end of storage; running past it is not defined
    function automatic logic [AW-1:0] addr_step(input logic [AW-1:0] a);
        if (a == AW'(DEPTH - 1)) begin
            return '0;
        end
        return a + 1'b1;
    endfunction

    // Index into the holding ring, modulo its depth
    function automatic logic [IW-1:0] ring_at(
        input logic [IW-1:0] base,
        input logic [HW-1:0] off
    );
        logic [HW:0] sum;
        sum = (HW + 1)'(base) + (HW + 1)'(off);
        if (sum >= (HW + 1)'(HOLD)) begin
            sum = sum - (HW + 1)'(HOLD);
        end
        return sum[IW-1:0];
    endfunction

    // ****************************************
    // Write port edge and holding ring
    // ****************************************
    always_comb begin
        w_edge = link.write_shift_clock & ~st_q.wclk;
        w_clr = w_edge & link.write_pointer_clear;
        push = w_edge & ~link.write_pointer_clear & link.input_advance_gate;
        hold_full = (st_q.count == HW'(HOLD));
        // Oldest entry leaves when the ring overflows or while draining
        commit = (push & hold_full) | ((st_q.flush_left != '0) & (st_q.count != '0));
        push_idx = ring_at(st_q.head, st_q.count);
        commit_addr = hold_addr[st_q.head];
        commit_data = hold_data[st_q.head];
    end

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        r_edge = link.output_shift_clock & ~st_q.rclk;
        st_d = st_q;
        // Only edges move the pointers, so a stopped clock holds them; a pending drain still commits
        st_d.wclk = link.write_shift_clock;
        st_d.rclk = link.output_shift_clock;

        // Holding ring bookkeeping
        if (commit) begin
            st_d.head = ring_at(st_q.head, HW'(1));
            if (st_q.flush_left != '0) begin
                st_d.flush_left = st_q.flush_left - 1'b1;
            end
        end
        st_d.count = st_q.count + HW'(push) - HW'(commit);

        // Write pointer
        if (w_clr) begin
            st_d.wr_ptr = '0;
            // New field entries stay held so a late read still sees the old field
            st_d.flush_left = st_d.count;
        end else if (push) begin
            st_d.wr_ptr = addr_step(st_q.wr_ptr);
        end

        // Read pointer and output nibble
        if (r_edge) begin
            if (link.output_pointer_clear) begin
                st_d.rd_ptr = '0;
            end else if (link.output_advance_gate) begin
                st_d.nibble = field_mem[st_q.rd_ptr];
                st_d.rd_ptr = addr_step(st_q.rd_ptr);
                st_d.oe = 1'b1;
            end
        end
    end

    // ****************************************
    // Registers
    // ****************************************
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    // Arrays keep their contents through reset
    always_ff @(posedge i_sys_clk) begin
        if (push) begin
            hold_data[push_idx] <= link.nibble_in;
            hold_addr[push_idx] <= st_q.wr_ptr;
        end
        if (commit) begin
            field_mem[commit_addr] <= commit_data;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign link.nibble_out = st_q.nibble;
    assign link.nibble_out_oe = st_q.oe;
    assign o_write_addr = st_q.wr_ptr;
    assign o_read_addr = st_q.rd_ptr;
    assign o_hold_level = st_q.count;

endmodule
`default_nettype wire

// *** dcf_video_ctl.sv ***
// Video controller end: drives both serial ports of the field memory
`timescale 1ns/10ps
`default_nettype none
module dcf_video_ctl #(
    parameter int HALF = dcf_pkg::SHIFT_HALF
) (
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_srst,
    // Link to the memory
    dcf_link_if.ctl link,
    // Write stream
    input wire logic i_wr_valid,
    input wire logic [dcf_pkg::NIB_W-1:0] i_wr_nibble,
    output logic o_wr_ready,
    input wire logic i_wr_field,
    // Read stream
    input wire logic i_rd_req,
    output logic o_rd_ready,
    output logic o_rd_valid,
    output logic [dcf_pkg::NIB_W-1:0] o_rd_nibble,
    input wire logic i_rd_field,
    // Status
    output logic o_init_done
);

    // ****************************************
    // State
    // ****************************************
    localparam int PW = (2 * HALF > 2) ? $clog2(2 * HALF) : 1;
    localparam int NW = dcf_pkg::NIB_W;
    localparam int AW = dcf_pkg::ACT_W;
    localparam int LW = dcf_pkg::LOW_W;
    localparam int SW = dcf_pkg::SPACE_W;

    typedef struct packed {
        dcf_pkg::dcf_ctl_state_t state;
        logic [dcf_pkg::TIMER_W-1:0] timer;
        logic [PW-1:0] wph;
        logic [PW-1:0] rph;
        logic wclk;
        logic wgate;
        logic wclr;
        logic [NW-1:0] wdata;
        logic rclk;
        logic rgate;
        logic rclr;
        logic [AW-1:0] w_act;
        logic [AW-1:0] r_act;
        logic [LW-1:0] w_low;
        logic [LW-1:0] r_low;
        logic [1:0] w_init;
        logic [1:0] r_init;
        logic w_pend;
        logic r_pend;
        logic [SW-1:0] since;
        logic capture;
        logic rd_valid;
        logic [NW-1:0] rd_nibble;
        logic wr_ready;
        logic rd_ready;
        logic init_done;
    } dcf_ctl_reg_t;

    dcf_ctl_reg_t st_q;
    dcf_ctl_reg_t st_d;

    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [PW-1:0] ph_step(input logic [PW-1:0] p);
        return (p == PW'(2 * HALF - 1)) ? '0 : p + 1'b1;
    endfunction

    function automatic logic may_clear(input logic [AW-1:0] act, input logic [LW-1:0] low);
        return (act >= AW'(dcf_pkg::MIN_ACTIVE)) && (low >= LW'(dcf_pkg::MIN_CLR_LOW));
    endfunction

    function automatic logic spacing_ok(input logic [SW-1:0] s);
        return (s <= SW'(dcf_pkg::OLD_MAX)) || (s >= SW'(dcf_pkg::NEW_MIN));
    endfunction

    // ****************************************
    // Next state
    // ****************************************
    logic w_slot;
    logic r_slot;
    logic w_do_clr;
    logic w_do_gate;
    logic r_do_clr;
    logic r_do_gate;

    always_comb begin
        st_d = st_q;
        st_d.rd_valid = 1'b0;
        w_do_clr = 1'b0;
        w_do_gate = 1'b0;
        r_do_clr = 1'b0;
        r_do_gate = 1'b0;
        w_slot = (st_q.state != dcf_pkg::ST_WAIT) && (st_q.wph == '0);
        r_slot = (st_q.state != dcf_pkg::ST_WAIT) && (st_q.rph == '0);

        case (st_q.state)
            dcf_pkg::ST_WAIT: begin
                if (st_q.timer == dcf_pkg::TIMER_W'(dcf_pkg::POWER_UP_CYC - 1)) begin
                    st_d.state = dcf_pkg::ST_INIT;
                end else begin
                    st_d.timer = st_q.timer + 1'b1;
                end
            end
            dcf_pkg::ST_INIT: begin
                if (st_q.w_init == dcf_pkg::INIT_DONE && st_q.r_init == dcf_pkg::INIT_DONE) begin
                    st_d.state = dcf_pkg::ST_RUN;
                    st_d.init_done = 1'b1;
                end
            end
            dcf_pkg::ST_RUN: begin
            end
            default: begin
                st_d.state = dcf_pkg::ST_WAIT;
            end
        endcase

        // Write slot: clear-130 dummies-clear, then user data
        if (w_slot) begin
            if (st_q.state == dcf_pkg::ST_INIT) begin
                if (st_q.w_init == dcf_pkg::INIT_CLR1) begin
                    w_do_clr = 1'b1;
                    st_d.w_init = dcf_pkg::INIT_DUMMY;
                end else if (st_q.w_init == dcf_pkg::INIT_DUMMY) begin
                    if (may_clear(st_q.w_act, st_q.w_low)) begin
                        w_do_clr = 1'b1;
                        st_d.w_init = dcf_pkg::INIT_DONE;
                    end else begin
                        w_do_gate = 1'b1;
                    end
                end
            end else if (st_q.state == dcf_pkg::ST_RUN) begin
                if (st_q.w_pend && may_clear(st_q.w_act, st_q.w_low)) begin
                    w_do_clr = 1'b1;
                end else if (i_wr_valid && st_q.wr_ready) begin
                    w_do_gate = 1'b1;
                    st_d.wdata = i_wr_nibble;
                end
            end
            st_d.wclr = w_do_clr;
            st_d.wgate = w_do_gate;
            if (w_do_clr) begin
                st_d.w_act = '0;
                st_d.w_low = '0;
                st_d.since = '0;
            end else begin
                if (st_q.w_low != '1) st_d.w_low = st_q.w_low + 1'b1;
                if (w_do_gate && st_q.w_act != '1) st_d.w_act = st_q.w_act + 1'b1;
                if (st_q.since != '1) st_d.since = st_q.since + 1'b1;
            end
        end

        // Read slot: hand over last nibble, then clear, dummy or fetch
        if (r_slot) begin
            if (st_q.capture) begin
                st_d.rd_valid = 1'b1;
                st_d.rd_nibble = link.nibble_out;
                st_d.capture = 1'b0;
            end
            if (st_q.state == dcf_pkg::ST_INIT) begin
                if (st_q.r_init == dcf_pkg::INIT_CLR1) begin
                    r_do_clr = 1'b1;
                    st_d.r_init = dcf_pkg::INIT_DUMMY;
                end else if (st_q.r_init == dcf_pkg::INIT_DUMMY) begin
                    if (may_clear(st_q.r_act, st_q.r_low)) begin
                        r_do_clr = 1'b1;
                        st_d.r_init = dcf_pkg::INIT_DONE;
                    end else begin
                        r_do_gate = 1'b1;
                    end
                end
            end else if (st_q.state == dcf_pkg::ST_RUN) begin
                if (st_q.r_pend && may_clear(st_q.r_act, st_q.r_low) && spacing_ok(st_q.since)) begin
                    r_do_clr = 1'b1;
                end else if (i_rd_req && st_q.rd_ready) begin
                    r_do_gate = 1'b1;
                    st_d.capture = 1'b1;
                end
            end
            st_d.rclr = r_do_clr;
            st_d.rgate = r_do_gate;
            if (r_do_clr) begin
                st_d.r_act = '0;
                st_d.r_low = '0;
            end else begin
                if (st_q.r_low != '1) st_d.r_low = st_q.r_low + 1'b1;
                if (r_do_gate && st_q.r_act != '1) st_d.r_act = st_q.r_act + 1'b1;
            end
        end

        // A new field request wins over the clear that retires the old one
        st_d.w_pend = (st_q.w_pend & ~(w_do_clr & (st_q.state == dcf_pkg::ST_RUN))) | i_wr_field;
        st_d.r_pend = (st_q.r_pend & ~(r_do_clr & (st_q.state == dcf_pkg::ST_RUN))) | i_rd_field;

        // Shift clocks: low in the first half, high in the second
        if (st_q.state != dcf_pkg::ST_WAIT) begin
            st_d.wph = ph_step(st_q.wph);
            st_d.rph = ph_step(st_q.rph);
        end
        st_d.wclk = (st_d.wph >= PW'(HALF));
        st_d.rclk = (st_d.rph >= PW'(HALF));

        st_d.wr_ready = (st_d.state == dcf_pkg::ST_RUN) && (st_d.wph == '0)
            && !(st_d.w_pend && may_clear(st_d.w_act, st_d.w_low));
        st_d.rd_ready = (st_d.state == dcf_pkg::ST_RUN) && (st_d.rph == '0)
            && !(st_d.r_pend && may_clear(st_d.r_act, st_d.r_low) && spacing_ok(st_d.since));
    end

    // ****************************************
    // Registers
    // ****************************************
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            st_q <= '0;
            st_q.state <= dcf_pkg::ST_WAIT;
            st_q.w_low <= LW'(dcf_pkg::MIN_CLR_LOW);
            st_q.r_low <= LW'(dcf_pkg::MIN_CLR_LOW);
            st_q.since <= SW'(dcf_pkg::NEW_MIN);
        end else begin
            st_q <= st_d;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign link.write_shift_clock = st_q.wclk;
    assign link.input_advance_gate = st_q.wgate;
    assign link.write_pointer_clear = st_q.wclr;
    assign link.nibble_in = st_q.wdata;
    assign link.output_shift_clock = st_q.rclk;
    assign link.output_advance_gate = st_q.rgate;
    assign link.output_pointer_clear = st_q.rclr;
    assign o_wr_ready = st_q.wr_ready;
    assign o_rd_ready = st_q.rd_ready;
    assign o_rd_valid = st_q.rd_valid;
    assign o_rd_nibble = st_q.rd_nibble;
    assign o_init_done = st_q.init_done;

endmodule
`default_nettype wire

// *** dcf_link_asserts.sv ***
// Checker of the serial link between the field memory and its controller
`timescale 1ns/10ps
`default_nettype none
module dcf_link_asserts (
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_srst,
    // Link signals
    input wire logic write_shift_clock,
    input wire logic input_advance_gate,
    input wire logic write_pointer_clear,
    input wire logic [dcf_pkg::NIB_W-1:0] nibble_in,
    input wire logic output_shift_clock,
    input wire logic output_advance_gate,
    input wire logic output_pointer_clear,
    input wire logic [dcf_pkg::NIB_W-1:0] nibble_out,
    input wire logic nibble_out_oe
);
    // ********
    // Helper state
    // ********
    typedef struct packed {
        logic wclk;
        logic rclk;
        logic [1:0] wlow;
        logic [1:0] rlow;
        logic [7:0] wact;
        logic [7:0] ract;
        logic [12:0] pwr;
    } dcf_chk_t;
    dcf_chk_t q;
    dcf_chk_t d;
    logic w_rise;
    logic r_rise;
    assign w_rise = write_shift_clock && !q.wclk;
    assign r_rise = output_shift_clock && !q.rclk;
    always_comb begin
        d = q;
        d.wclk = write_shift_clock;
        d.rclk = output_shift_clock;
        d.pwr = q.pwr + {12'h000, q.pwr != 13'h1fff};
        if (w_rise && write_pointer_clear) begin
            d.wlow = 2'h0;
            d.wact = 8'h00;
        end else if (w_rise) begin
            d.wlow = q.wlow + {1'b0, q.wlow != 2'h3};
            d.wact = q.wact + {7'h00, input_advance_gate && q.wact != 8'hff};
        end
        if (r_rise && output_pointer_clear) begin
            d.rlow = 2'h0;
            d.ract = 8'h00;
        end else if (r_rise) begin
            d.rlow = q.rlow + {1'b0, q.rlow != 2'h3};
            d.ract = q.ract + {7'h00, output_advance_gate && q.ract != 8'hff};
        end
    end
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            q <= {2'h0, 2'h3, 2'h3, 8'hff, 8'hff, 13'h0000};
        end else begin
            q <= d;
        end
    end
    // ********
    // Properties
    // ********
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_srst);
    sequence s_wclr_edge;
        w_rise && write_pointer_clear;
    endsequence
    sequence s_rclr_edge;
        r_rise && output_pointer_clear;
    endsequence
    sequence s_gated_read;
        r_rise && output_advance_gate && !output_pointer_clear;
    endsequence
    a_wclr_low_two: assert property (s_wclr_edge |-> q.wlow >= 2'h2)
        else $error("write clear raised too soon");
    a_rclr_low_two: assert property (s_rclr_edge |-> q.rlow >= 2'h2)
        else $error("read clear raised too soon");
    a_wr_active_min: assert property (s_wclr_edge |-> q.wact >= dcf_pkg::MIN_ACTIVE)
        else $error("too few gated writes before clear");
    a_rd_active_min: assert property (s_rclr_edge |-> q.ract >= dcf_pkg::MIN_ACTIVE)
        else $error("too few gated reads before clear");
    a_power_quiet: assert property (q.pwr < dcf_pkg::POWER_UP_CYC |->
        !write_shift_clock && !output_shift_clock)
        else $error("shift clock before power up wait");
    a_oe_stays: assert property (nibble_out_oe |=> nibble_out_oe)
        else $error("output enable dropped");
    a_read_drives: assert property (s_gated_read |=> nibble_out_oe)
        else $error("output not driven after read");
    a_gate_low_hold: assert property (r_rise && !output_advance_gate |=> $stable(nibble_out))
        else $error("output moved with read gate low");
    a_out_only_shift: assert property ($changed(nibble_out) |-> $past(r_rise))
        else $error("output moved without read edge");
endmodule
`default_nettype wire

// *** dual_clock_field_fifo_tb.sv ***
// Testbench of the field memory and its controller joined by the link
`timescale 1ns/10ps
`default_nettype none
module dual_clock_field_fifo_tb;
    // ********
    // Signals
    // ********
    localparam int DP = 1024;
    logic i_sys_clk = 1'b0;
    logic i_srst = 1'b1;
    logic i_wr_valid = 1'b0;
    logic [3:0] i_wr_nibble = 4'h0;
    logic i_wr_field = 1'b0;
    logic i_rd_req = 1'b0;
    logic i_rd_field = 1'b0;
    logic o_wr_ready, o_rd_ready, o_rd_valid, o_init_done;
    logic [3:0] o_rd_nibble;
    logic [9:0] wa, ra, wa2, ra2;
    logic [9:0] rdy = 10'h000;
    logic [6:0] hl;
    logic [3:0] wdat [2048];
    int err_count = 0;
    int num_checks = 0;
    int cyc = 0;
    dcf_link_if link ();
    dcf_link_if link2 ();
    dcf_field_mem #(.DEPTH(DP)) dcf_field_mem_inst (.i_sys_clk(i_sys_clk), .i_srst(i_srst),
        .link(link.dev), .o_write_addr(wa), .o_read_addr(ra), .o_hold_level(hl));
    dcf_field_mem #(.DEPTH(DP)) dcf_field_mem_inst_b (.i_sys_clk(i_sys_clk), .i_srst(i_srst),
        .link(link2.dev), .o_write_addr(wa2), .o_read_addr(ra2), .o_hold_level());
    dcf_video_ctl dcf_video_ctl_inst (.i_sys_clk(i_sys_clk), .i_srst(i_srst), .link(link.ctl),
        .i_wr_valid(i_wr_valid), .i_wr_nibble(i_wr_nibble), .o_wr_ready(o_wr_ready),
        .i_wr_field(i_wr_field), .i_rd_req(i_rd_req), .o_rd_ready(o_rd_ready),
        .o_rd_valid(o_rd_valid), .o_rd_nibble(o_rd_nibble), .i_rd_field(i_rd_field),
        .o_init_done(o_init_done));
    dcf_link_asserts dcf_link_asserts_inst (.i_sys_clk(i_sys_clk), .i_srst(i_srst),
        .write_shift_clock(link.write_shift_clock), .input_advance_gate(link.input_advance_gate),
        .write_pointer_clear(link.write_pointer_clear), .nibble_in(link.nibble_in),
        .output_shift_clock(link.output_shift_clock),
        .output_advance_gate(link.output_advance_gate),
        .output_pointer_clear(link.output_pointer_clear), .nibble_out(link.nibble_out),
        .nibble_out_oe(link.nibble_out_oe));
    // ********
    // Tasks
    // ********
    task print_verdict();
        if (err_count == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task chk(input logic [9:0] got, input logic [9:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task edge2(input bit clr, input bit gate, input logic [9:0] exp);
        link2.write_pointer_clear = clr;
        link2.output_pointer_clear = clr;
        link2.input_advance_gate = gate;
        link2.output_advance_gate = gate;
        link2.nibble_in = 4'($urandom);
        repeat (2) @(negedge i_sys_clk);
        link2.write_shift_clock = 1'b1;
        link2.output_shift_clock = 1'b1;
        repeat (2) @(negedge i_sys_clk);
        link2.write_shift_clock = 1'b0;
        link2.output_shift_clock = 1'b0;
        chk(wa2, exp);
        chk(ra2, exp);
    endtask
    task wr(input int base, input int n, input bit gaps);
        int i;
        i = 0;
        while (i < n) begin
            @(negedge i_sys_clk);
            i_wr_valid = !gaps || ($urandom_range(3) != 0);
            i_wr_nibble = wdat[base+i];
            if ((o_wr_ready && i_wr_valid) === 1'b1) i++;
            @(posedge i_sys_clk);
        end
        @(negedge i_sys_clk);
        i_wr_valid = 1'b0;
    endtask
    task fld(input bit rd);
        @(negedge i_sys_clk);
        i_rd_field = rd;
        i_wr_field = !rd;
        @(negedge i_sys_clk);
        i_rd_field = 1'b0;
        i_wr_field = 1'b0;
    endtask
    task wait_clr(input bit rd);
        int k;
        k = 0;
        while ((rd ? link.output_pointer_clear : link.write_pointer_clear) !== 1'b1 && k < 3000) begin
            @(negedge i_sys_clk);
            k++;
        end
        chk({9'h000, k >= 3000}, 10'h000);
    endtask
    task rd(input int base, input int n);
        int k;
        int t;
        k = 0;
        t = 0;
        @(negedge i_sys_clk);
        i_rd_req = 1'b1;
        while (k < n && t < 4000) begin
            @(negedge i_sys_clk);
            t++;
            if (o_rd_valid === 1'b1) begin
                chk({6'h00, o_rd_nibble}, {6'h00, wdat[base+k]});
                chk({9'h000, link.nibble_out_oe}, 10'h001);
                k++;
            end
        end
        @(negedge i_sys_clk);
        i_rd_req = 1'b0;
        chk({9'h000, t >= 4000}, 10'h000);
    endtask
    // ********
    // Clock, timeout and sequence
    // ********
    initial begin
        forever #12.5 i_sys_clk = ~i_sys_clk;
    end
    always @(posedge i_sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            err_count++;
            print_verdict();
        end
    end
    initial begin
        link2.write_shift_clock = 1'b0;
        link2.output_shift_clock = 1'b0;
        link2.write_pointer_clear = 1'b0;
        link2.output_pointer_clear = 1'b0;
        link2.input_advance_gate = 1'b0;
        link2.output_advance_gate = 1'b0;
        link2.nibble_in = 4'h0;
        void'($urandom(85));
        foreach (wdat[j]) wdat[j] = 4'($urandom);
        repeat (10) @(negedge i_sys_clk);
        i_srst = 1'b0;
        edge2(1'b1, 1'b1, 10'h000);
        edge2(1'b0, 1'b1, 10'h001);
        edge2(1'b0, 1'b1, 10'h002);
        repeat (50) @(negedge i_sys_clk);
        edge2(1'b0, 1'b0, 10'h002);
        edge2(1'b1, 1'b1, 10'h000);
        while (o_init_done !== 1'b1) @(negedge i_sys_clk);
        repeat (8) begin
            @(negedge i_sys_clk);
            rdy = rdy + o_rd_ready + o_wr_ready;
        end
        chk(rdy, 10'h004);
        chk(wa, 10'h000);
        chk(ra, 10'h000);
        wr(0, 300, 1'b1);
        repeat (8) @(negedge i_sys_clk);
        chk(wa, 10'h12c);
        chk({3'h0, hl}, 10'h078);
        rd(0, 130);
        fld(1'b0);
        wait_clr(1'b0);
        fld(1'b1);
        fork
            wr(512, 300, 1'b1);
            begin
                wait_clr(1'b1);
                rd(0, 300);
            end
        join
        fld(1'b0);
        wait_clr(1'b0);
        fork
            wr(1024, 700, 1'b0);
            begin
                repeat (600) @(negedge i_sys_clk);
                fld(1'b1);
                wait_clr(1'b1);
                chk({9'h000, wa >= 10'h258}, 10'h001);
                rd(1024, 300);
            end
        join
        print_verdict();
    end
endmodule
`default_nettype wire
